//--- verilog/fault_sup_pkg.sv
// shared constants, types and register map of the drive fault supervisor
package fault_sup_pkg;

	// apb register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STOP_DIST_OFS = 8'h04;
	localparam logic [7:0] SPEED_LIMIT_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] HIST_SEL_OFS = 8'h10;
	localparam logic [7:0] HIST_DATA_OFS = 8'h14;
	localparam logic [7:0] HIST_COUNT_OFS = 8'h18;
	localparam logic [7:0] MON_SPEED_OFS = 8'h1c;
	localparam logic [7:0] MON_DIST_OFS = 8'h20;

	// control register fields
	localparam int CTRL_LINK_EN_BIT = 0;
	localparam int CTRL_CAN_MODE_BIT = 1;
	localparam int CTRL_EARLY_STOP_BIT = 2;
	localparam int CTRL_CONTACTORS_BIT = 3;
	localparam int CTRL_HIST_CLR_BIT = 4;

	// reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] STOP_DIST_RST = 16'h0023;
	localparam logic [15:0] SPEED_LIMIT_RST = 16'h0100;

	// fault codes kept until power cycle, and the can error warning limit
	localparam logic [9:0] LOCK_CODE_LO = 10'h384;
	localparam logic [9:0] LOCK_CODE_HI = 10'h3e7;
	localparam logic [7:0] CAN_WARN_LIMIT = 8'h60;

	// timing
	localparam int CLOCK_KHZ = 40000;
	localparam int HOLDOFF_MS = 2000;
	localparam int HOLDOFF_CYCLES = HOLDOFF_MS * CLOCK_KHZ;
	localparam int LED_TICK_US = 62500;
	localparam int LED_TICK_CYCLES = LED_TICK_US * (CLOCK_KHZ / 1000);

	// history sizing
	localparam int HIST_DEPTH = 64;

	// fault supervision states
	typedef enum logic [1:0] {SUP_OK, SUP_ACTIVE, SUP_HOLD, SUP_LOCKED} sup_state_t;

	// can node operating states
	localparam logic [1:0] CAN_STOPPED = 2'h0;
	localparam logic [1:0] CAN_PREOP = 2'h1;
	localparam logic [1:0] CAN_OPER = 2'h2;

	// external pins, all from outside the clock domain
	typedef struct packed {
		logic fault_detect;
		logic [9:0] fault_code;
		logic [2:0] speed_preset_inputs;
		logic travel_enable;
		logic link_ok;
		logic [1:0] can_state;
		logic [7:0] can_err_cnt;
		logic can_bus_off;
		logic monitor_req;
		logic [2:0] fw_err_code;
		logic evac_active;
		logic lowest_step_off;
		logic brake_evac;
		logic [15:0] evac_speed;
		logic evac_up;
		logic [15:0] evac_dist;
		logic [15:0] remain_mm;
	} pins_t;

	// one fault history entry
	typedef struct packed {
		logic [15:0] trip_count;
		logic travelling;
		logic [9:0] code;
	} hist_entry_t;

endpackage

//--- verilog/drive_fault_supervisor.sv
// drive fault supervisor: travel abort, auto acknowledge, history, led, monitor mode
`timescale 1ns/10ps

module drive_fault_supervisor #(
	parameter int HOLDOFF_CYCLES = fault_sup_pkg::HOLDOFF_CYCLES,
	parameter int LED_TICK_CYCLES = fault_sup_pkg::LED_TICK_CYCLES,
	parameter int HIST_DEPTH = fault_sup_pkg::HIST_DEPTH
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fault_sup_pkg::pins_t pins,
	output logic malfunction_output,
	output logic controller_ready_output,
	output logic brake_release_output,
	output logic winding_short,
	output logic led_green,
	output logic led_red,
	output logic monitor_active,
	output logic arrow_double
);

	localparam int PW = $clog2(HIST_DEPTH);

	// elaboration check: history must be a power of two for pointer wrap
	if (HIST_DEPTH < 2 || (1 << PW) != HIST_DEPTH || HOLDOFF_CYCLES < 1 || LED_TICK_CYCLES < 1)
	begin : bad_param
		$error("drive_fault_supervisor: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////////////
	// input synchroniser; multi-bit fields assumed quasi-static around sampling
	fault_sup_pkg::pins_t sync1_r;
	fault_sup_pkg::pins_t pin_r;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= '0;
			pin_r <= '0;
		end
		else
		begin
			sync1_r <= pins;
			pin_r <= sync1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power-on capture of monitor request, after the synchroniser has filled
	logic [1:0] por_cnt_r, por_cnt_nxt;
	logic monitor_r, monitor_nxt;

	always_comb
	begin
		por_cnt_nxt = por_cnt_r;
		monitor_nxt = monitor_r;
		if (por_cnt_r != 2'h3)
			por_cnt_nxt = por_cnt_r + 2'h1;
		if (por_cnt_r == 2'h2)
			monitor_nxt = pin_r.monitor_req;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_cnt_r <= 2'h0;
			monitor_r <= 1'b0;
		end
		else
		begin
			por_cnt_r <= por_cnt_nxt;
			monitor_r <= monitor_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb register file; one wait state so read data comes from a flop
	logic [3:0] ctrl_r, ctrl_nxt;
	logic [15:0] stop_dist_r, stop_dist_nxt;
	logic [15:0] speed_limit_r, speed_limit_nxt;
	logic [PW-1:0] hist_sel_r, hist_sel_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt;
	logic acc, wr_en, hist_clr;
	logic [31:0] rd_val;
	logic rd_err;
	fault_sup_pkg::sup_state_t state_r, state_nxt;
	logic [9:0] code_r, code_nxt;
	logic [PW:0] hist_cnt_r, hist_cnt_nxt;
	fault_sup_pkg::hist_entry_t hist_rd;

	assign acc = psel && penable && !pready;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;
	assign hist_clr = wr_en && paddr == fault_sup_pkg::CTRL_OFS
		&& pwdata[fault_sup_pkg::CTRL_HIST_CLR_BIT];

	// read mux and address decode
	always_comb
	begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		if (paddr == fault_sup_pkg::CTRL_OFS)
			rd_val = {28'h0, ctrl_r};
		else if (paddr == fault_sup_pkg::STOP_DIST_OFS)
			rd_val = {16'h0, stop_dist_r};
		else if (paddr == fault_sup_pkg::SPEED_LIMIT_OFS)
			rd_val = {16'h0, speed_limit_r};
		else if (paddr == fault_sup_pkg::STATUS_OFS)
			rd_val = {16'h0, monitor_r, 3'h0, state_r, code_r};
		else if (paddr == fault_sup_pkg::HIST_SEL_OFS)
			rd_val = 32'(hist_sel_r);
		else if (paddr == fault_sup_pkg::HIST_DATA_OFS)
			rd_val = 32'(hist_rd);
		else if (paddr == fault_sup_pkg::HIST_COUNT_OFS)
			rd_val = 32'(hist_cnt_r);
		else if (paddr == fault_sup_pkg::MON_SPEED_OFS)
			rd_val = {14'h0, arrow_double, pin_r.evac_up, pin_r.evac_speed};
		else if (paddr == fault_sup_pkg::MON_DIST_OFS)
			rd_val = {16'h0, pin_r.evac_dist};
		else
			rd_err = 1'b1;
	end

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		stop_dist_nxt = stop_dist_r;
		speed_limit_nxt = speed_limit_r;
		hist_sel_nxt = hist_sel_r;
		pready_nxt = acc;
		pslverr_nxt = acc && rd_err;
		prdata_nxt = (acc && !pwrite) ? rd_val : 32'h0;
		if (wr_en)
		begin
			if (paddr == fault_sup_pkg::CTRL_OFS)
				ctrl_nxt = pwdata[3:0];
			else if (paddr == fault_sup_pkg::STOP_DIST_OFS)
				stop_dist_nxt = pwdata[15:0];
			else if (paddr == fault_sup_pkg::SPEED_LIMIT_OFS)
				speed_limit_nxt = pwdata[15:0];
			else if (paddr == fault_sup_pkg::HIST_SEL_OFS)
				hist_sel_nxt = pwdata[PW-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= fault_sup_pkg::CTRL_RST;
			stop_dist_r <= fault_sup_pkg::STOP_DIST_RST;
			speed_limit_r <= fault_sup_pkg::SPEED_LIMIT_RST;
			hist_sel_r <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			stop_dist_r <= stop_dist_nxt;
			speed_limit_r <= speed_limit_nxt;
			hist_sel_r <= hist_sel_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault supervision: detect, hold-off, acknowledge, power-cycle lock
	logic [31:0] hold_cnt_r, hold_cnt_nxt;
	logic any_speed, lock_code, new_fault;

	assign any_speed = |pin_r.speed_preset_inputs;
	assign lock_code = pin_r.fault_code >= fault_sup_pkg::LOCK_CODE_LO
		&& pin_r.fault_code <= fault_sup_pkg::LOCK_CODE_HI;
	assign new_fault = state_r == fault_sup_pkg::SUP_OK && pin_r.fault_detect && !monitor_r;

	always_comb
	begin
		state_nxt = state_r;
		code_nxt = code_r;
		hold_cnt_nxt = hold_cnt_r;
		case (state_r)
			fault_sup_pkg::SUP_OK:
				if (new_fault)
				begin
					code_nxt = pin_r.fault_code;
					state_nxt = lock_code ? fault_sup_pkg::SUP_LOCKED
						: fault_sup_pkg::SUP_ACTIVE;
				end
			fault_sup_pkg::SUP_ACTIVE:
				if (pin_r.fault_detect && lock_code)
				begin
					code_nxt = pin_r.fault_code;
					state_nxt = fault_sup_pkg::SUP_LOCKED;
				end
				else if (!pin_r.fault_detect)
				begin
					hold_cnt_nxt = 32'h0;
					state_nxt = fault_sup_pkg::SUP_HOLD;
				end
			fault_sup_pkg::SUP_HOLD:
				if (pin_r.fault_detect)
					state_nxt = fault_sup_pkg::SUP_ACTIVE;
				else if (any_speed)
					hold_cnt_nxt = 32'h0;
				else if (hold_cnt_r == 32'(HOLDOFF_CYCLES - 1))
					state_nxt = fault_sup_pkg::SUP_OK;
				else
					hold_cnt_nxt = hold_cnt_r + 32'h1;
			default:
				state_nxt = fault_sup_pkg::SUP_LOCKED; // cleared by reset only
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= fault_sup_pkg::SUP_OK;
			code_r <= 10'h0;
			hold_cnt_r <= 32'h0;
		end
		else
		begin
			state_r <= state_nxt;
			code_r <= code_nxt;
			hold_cnt_r <= hold_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault history ring; newest at index 0 on readout
	fault_sup_pkg::hist_entry_t hist_mem [HIST_DEPTH];
	logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
	logic [15:0] trip_cnt_r, trip_cnt_nxt;
	logic [PW-1:0] rd_idx;
	fault_sup_pkg::hist_entry_t new_entry;
	logic brake_release_nxt;

	assign rd_idx = wr_ptr_r - PW'(1) - hist_sel_r;
	assign hist_rd = (hist_sel_r < hist_cnt_r) ? hist_mem[rd_idx] : '0;
	assign new_entry = '{trip_count: trip_cnt_r, travelling: brake_release_output,
		code: pin_r.fault_code};

	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		hist_cnt_nxt = hist_cnt_r;
		trip_cnt_nxt = trip_cnt_r;
		if (brake_release_nxt && !brake_release_output)
			trip_cnt_nxt = trip_cnt_r + 16'h1;
		if (hist_clr)
		begin
			wr_ptr_nxt = '0;
			hist_cnt_nxt = '0;
		end
		else if (new_fault)
		begin
			wr_ptr_nxt = wr_ptr_r + PW'(1); // wraps onto the oldest
			if (hist_cnt_r != (PW+1)'(HIST_DEPTH))
				hist_cnt_nxt = hist_cnt_r + (PW+1)'(1);
		end
	end

	// memory itself has no reset; the count says which entries are valid
	always_ff @(posedge clock)
	begin
		if (new_fault && !hist_clr)
			hist_mem[wr_ptr_r] <= new_entry;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			hist_cnt_r <= '0;
			trip_cnt_r <= 16'h0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			hist_cnt_r <= hist_cnt_nxt;
			trip_cnt_r <= trip_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// travel outputs, early brake stop and winding short
	logic stop_latch_r, stop_latch_nxt;
	logic fault_ok, stop_hit;

	assign fault_ok = state_nxt == fault_sup_pkg::SUP_OK;
	assign stop_hit = (ctrl_r[fault_sup_pkg::CTRL_EARLY_STOP_BIT] && pin_r.evac_active
		&& pin_r.lowest_step_off)
		|| (ctrl_r[fault_sup_pkg::CTRL_LINK_EN_BIT] && pin_r.remain_mm == stop_dist_r);
	assign brake_release_nxt = fault_ok && !monitor_r && pin_r.travel_enable && any_speed
		&& !stop_latch_nxt;

	// brake stays closed until the travel command is withdrawn
	always_comb
	begin
		stop_latch_nxt = stop_latch_r;
		if (!any_speed)
			stop_latch_nxt = 1'b0;
		else if (stop_hit)
			stop_latch_nxt = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stop_latch_r <= 1'b0;
			malfunction_output <= 1'b0;
			controller_ready_output <= 1'b0;
			brake_release_output <= 1'b0;
			winding_short <= 1'b0;
			monitor_active <= 1'b0;
			arrow_double <= 1'b0;
		end
		else
		begin
			stop_latch_r <= stop_latch_nxt;
			malfunction_output <= fault_ok;
			controller_ready_output <= fault_ok && !monitor_r;
			brake_release_output <= brake_release_nxt;
			winding_short <= pin_r.brake_evac && !ctrl_r[fault_sup_pkg::CTRL_CONTACTORS_BIT];
			monitor_active <= monitor_r;
			arrow_double <= monitor_r && pin_r.evac_speed > speed_limit_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// led timebase: 16 ticks per second, 5-bit phase spans two seconds
	logic [31:0] tick_cnt_r, tick_cnt_nxt;
	logic [4:0] phase_r, phase_nxt;
	logic green_nxt, red_nxt;

	always_comb
	begin
		tick_cnt_nxt = tick_cnt_r + 32'h1;
		phase_nxt = phase_r;
		if (tick_cnt_r == 32'(LED_TICK_CYCLES - 1))
		begin
			tick_cnt_nxt = 32'h0;
			phase_nxt = phase_r + 5'h1;
		end
	end

	// pattern select; green operation, red errors; both at once in can and standard patterns, one at a time in link patterns; fw error code blanks green
	always_comb
	begin
		green_nxt = 1'b0;
		red_nxt = 1'b0;
		if (pin_r.fw_err_code != 3'h0)
			red_nxt = !phase_r[0] && (phase_r[4:1] < {1'b0, pin_r.fw_err_code});
		else if (ctrl_r[fault_sup_pkg::CTRL_CAN_MODE_BIT])
		begin
			case (pin_r.can_state)
				fault_sup_pkg::CAN_STOPPED: green_nxt = !phase_r[3];
				fault_sup_pkg::CAN_PREOP: green_nxt = phase_r[0];
				fault_sup_pkg::CAN_OPER: green_nxt = 1'b1;
				default: green_nxt = 1'b0;
			endcase
			if (pin_r.can_bus_off)
				red_nxt = 1'b1;
			else if (pin_r.can_err_cnt > fault_sup_pkg::CAN_WARN_LIMIT)
				red_nxt = !phase_r[3];
		end
		else if (ctrl_r[fault_sup_pkg::CTRL_LINK_EN_BIT])
		begin
			green_nxt = pin_r.link_ok;
			red_nxt = !pin_r.link_ok && phase_r[0];
		end
		else if (pin_r.link_ok)
		begin
			green_nxt = !phase_r[4];
			red_nxt = phase_r[4];
		end
		else
		begin
			green_nxt = brake_release_output ? !phase_r[2] : !phase_r[3];
			red_nxt = !fault_ok;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_r <= 32'h0;
			phase_r <= 5'h0;
			led_green <= 1'b0;
			led_red <= 1'b0;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_nxt;
			phase_r <= phase_nxt;
			led_green <= green_nxt;
			led_red <= red_nxt;
		end
	end

endmodule

//--- tb/fault_sup_props.sv
// checker for the drive fault supervisor ports
`timescale 1ns/10ps
module fault_sup_props #(
	parameter int HOLDOFF_CYCLES = fault_sup_pkg::HOLDOFF_CYCLES
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire fault_sup_pkg::pins_t pins,
	input wire logic malfunction_output,
	input wire logic controller_ready_output,
	input wire logic brake_release_output,
	input wire logic winding_short,
	input wire logic led_green,
	input wire logic led_red,
	input wire logic monitor_active,
	input wire logic arrow_double
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [2:0] boot_r, boot_nxt;
	int quiet_r, quiet_nxt;
	logic lock_r, lock_nxt;
	////////////////////////////////////////////////////////////////
	// quiet time counted at the pins, so it leads the design's own count
	always_comb
	begin
		boot_nxt = (boot_r == 3'h7) ? boot_r : boot_r + 3'h1;
		quiet_nxt = (pins.fault_detect || pins.speed_preset_inputs != 3'h0) ? 0 : quiet_r + 1;
		if (quiet_r > HOLDOFF_CYCLES + 8)
			quiet_nxt = quiet_r;
		lock_nxt = lock_r | (pins.fault_detect & !monitor_active &
			pins.fault_code >= 10'h384 & pins.fault_code <= 10'h3e7);
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			boot_r <= 3'h0;
			quiet_r <= 0;
			lock_r <= 1'b0;
		end
		else
		begin
			boot_r <= boot_nxt;
			quiet_r <= quiet_nxt;
			lock_r <= lock_nxt;
		end
	end
	////////////////////////////////////////////////////////////////
	a_fault_abort: assert property (
		$rose(pins.fault_detect) && !monitor_active |-> ##3
		!(malfunction_output | controller_ready_output | brake_release_output))
		else $error("outputs not dropped on fault");
	a_brake_needs_ok: assert property (
		brake_release_output |-> malfunction_output)
		else $error("brake open while faulted");
	a_ack_holdoff: assert property (
		$rose(malfunction_output) |-> boot_r < 3'h4 || quiet_r >= HOLDOFF_CYCLES)
		else $error("fault cleared before quiet hold-off");
	a_lock_kept: assert property (
		$rose(malfunction_output) |-> !lock_r)
		else $error("locked fault acknowledged");
	a_monitor_hold: assert property (
		!$fell(monitor_active))
		else $error("monitor mode left without reset");
	a_monitor_inhibit: assert property (
		monitor_active |-> !controller_ready_output && !brake_release_output)
		else $error("travel allowed in monitor mode");
	a_arrow_mon: assert property (
		arrow_double |-> monitor_active)
		else $error("double arrow outside monitor mode");
	a_apb_wait: assert property (
		psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (
		pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule
bind drive_fault_supervisor fault_sup_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) props_u (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pins(pins), .malfunction_output(malfunction_output),
	.controller_ready_output(controller_ready_output),
	.brake_release_output(brake_release_output), .winding_short(winding_short),
	.led_green(led_green), .led_red(led_red), .monitor_active(monitor_active),
	.arrow_double(arrow_double));

//--- tb/ctl_model.sv
// elevator control system model: travel request and abort reaction
`timescale 1ns/10ps
module ctl_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic go,
	input wire logic slow,
	input wire logic controller_ready_output,
	output logic travel_enable,
	output logic [2:0] speed_preset_inputs
);
	logic abort_r, abort_nxt, rdy_r;
	logic [2:0] lag_r, lag_nxt;
	////////////////////////////////////////////////////////////////
	// a ready drop ends the trip until go is released
	always_comb
	begin
		abort_nxt = go & (abort_r | (rdy_r & !controller_ready_output));
		lag_nxt = !go ? 3'h0 : (lag_r == 3'h7 ? lag_r : lag_r + 3'h1);
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			abort_r <= 1'b0;
			rdy_r <= 1'b0;
			lag_r <= 3'h0;
		end
		else
		begin
			abort_r <= abort_nxt;
			rdy_r <= controller_ready_output;
			lag_r <= lag_nxt;
		end
	end
	// slow start waits longer before the speed preset comes
	assign travel_enable = go & !abort_r & (lag_r >= (slow ? 3'h6 : 3'h1));
	assign speed_preset_inputs = travel_enable ? 3'h1 : 3'h0;
endmodule

//--- tb/drive_fault_supervisor_tb.sv
// self-checking bench for the drive fault supervisor
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", nm, e, s); end end
module drive_fault_supervisor_tb;
	localparam int HOLD = 200;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, go, slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic malf, rdy, brk, wshort, lgreen, lred, mon, arrow, t_en;
	logic [2:0] spd;
	logic [9:0] c [0:4];
	logic [15:0] evs;
	fault_sup_pkg::pins_t pin_r, pins_w;
	logic [64:0] q [$];
	int err_count, n_tests;
	wire [1:0] obs = {brk, malf};
	always_comb
	begin
		pins_w = pin_r;
		pins_w.travel_enable = t_en;
		pins_w.speed_preset_inputs = spd;
	end
	drive_fault_supervisor #(.HOLDOFF_CYCLES(HOLD), .LED_TICK_CYCLES(4), .HIST_DEPTH(4)) dut_u (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins_w), .malfunction_output(malf), .controller_ready_output(rdy),
		.brake_release_output(brk), .winding_short(wshort), .led_green(lgreen),
		.led_red(lred), .monitor_active(mon), .arrow_double(arrow));
	ctl_model ctl_u (.clock(clock), .rst_n(rst_n), .go(go), .slow(slow),
		.controller_ready_output(rdy), .travel_enable(t_en), .speed_preset_inputs(spd));
	////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// apb master, request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do
			@(posedge clock);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
		q.push_back({m, e});
		apb(1'b0, a, 32'h0);
	endtask
	task wait_o(input int k, input logic v, input int lim);
		for (int n = 0; n < lim && obs[k] !== v; n++)
			@(posedge clock);
	endtask
	// led activity over 128 cycles, {high cycles, rising edges} per colour
	task led_win(input string nm, input logic [15:0] e_g, input logic [15:0] e_r);
		logic [7:0] gh, gr, rh, rr;
		logic pg, pr;
		repeat (8) @(posedge clock);
		{gh, gr, rh, rr} = '0;
		pg = lgreen;
		pr = lred;
		repeat (128)
		begin
			@(posedge clock);
			gh = gh + {7'h0, lgreen};
			gr = gr + {7'h0, lgreen & !pg};
			rh = rh + {7'h0, lred};
			rr = rr + {7'h0, lred & !pr};
			pg = lgreen;
			pr = lred;
		end
		`CHK(nm, {e_g, e_r}, {gh, gr, rh, rr})
	endtask
	// read results taken off the queue as they appear
	always @(posedge clock)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			if (q.size() == 0)
				`CHK("queue", 1'b1, 1'b0)
			else
			begin
				`CHK("prdata", {q[0][32], q[0][31:0] & q[0][64:33]},
					{pslverr, prdata & q[0][64:33]})
				void'(q.pop_front());
			end
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// watchdog well above the few thousand cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		conclude();
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(45));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pin_r = '0;
		pin_r.remain_mm = 16'h1000;
		pin_r.can_err_cnt = 8'($urandom);
		pin_r.link_ok = 1'b0;
		{go, slow, rst_n} = 3'h2;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
		`CHK("mon_off", 1'b0, mon)
		rd(fault_sup_pkg::CTRL_OFS, 33'h0, '1);
		rd(fault_sup_pkg::STOP_DIST_OFS, 33'h23, '1);
		rd(fault_sup_pkg::SPEED_LIMIT_OFS, 33'h100, '1);
		rd(8'h40, {1'b1, 32'h0}, '1);
		for (int i = 0; i < 5; i++)
		begin
			c[i] = 10'($urandom_range(899, 1));
			if (i == 0)
			begin
				go <= 1'b1;
				wait_o(1, 1'b1, 40);
				`CHK("brake_open", 1'b1, brk)
			end
			pin_r.fault_code <= c[i];
			pin_r.fault_detect <= 1'b1;
			repeat (4) @(posedge clock);
			`CHK("abort", 3'h0, {malf, rdy, brk})
			{go, slow} <= 2'h0;
			pin_r.fault_detect <= 1'b0;
			repeat (100) @(posedge clock);
			`CHK("held", 1'b0, malf)
			if (i == 1)
				pin_r.fault_detect <= 1'b1;
			if (i == 2)
				go <= 1'b1;
			@(posedge clock);
			pin_r.fault_detect <= 1'b0;
			repeat (150) @(posedge clock);
			go <= 1'b0;
			if (i == 1)
				`CHK("restart", 1'b0, malf)
			if (i == 2)
				`CHK("withheld", 1'b0, malf)
			wait_o(0, 1'b1, HOLD + 60);
			`CHK("ack", 1'b1, malf)
		end
		rd(fault_sup_pkg::HIST_COUNT_OFS, 33'h4, '1);
		apb(1'b1, fault_sup_pkg::HIST_SEL_OFS, 32'h0);
		rd(fault_sup_pkg::HIST_DATA_OFS, {23'h0, c[4]}, 32'h3ff);
		apb(1'b1, fault_sup_pkg::HIST_SEL_OFS, 32'h3);
		rd(fault_sup_pkg::HIST_DATA_OFS, {23'h0, c[1]}, 32'h3ff);
		// link stop distance, then early stop in evacuation
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, fault_sup_pkg::CTRL_OFS, k ? 32'h4 : 32'h1);
			rd(fault_sup_pkg::CTRL_OFS, k ? 33'h4 : 33'h1, '1);
			go <= 1'b1;
			wait_o(1, 1'b1, 40);
			`CHK("trip", 1'b1, brk)
			if (k)
				led_win("led_travel", 16'h4004, 16'h0000);
			if (k)
				{pin_r.evac_active, pin_r.lowest_step_off} <= 2'h3;
			else
				pin_r.remain_mm <= 16'd35;
			repeat (4) @(posedge clock);
			`CHK("stop", 1'b0, brk)
			go <= 1'b0;
			pin_r.remain_mm <= 16'h1000;
			{pin_r.evac_active, pin_r.lowest_step_off} <= 2'h0;
			repeat (4) @(posedge clock);
		end
		c[0] = 10'($urandom_range(999, 900));
		pin_r.fault_code <= c[0];
		pin_r.fault_detect <= 1'b1;
		repeat (4) @(posedge clock);
		pin_r.fault_detect <= 1'b0;
		repeat (HOLD + 60) @(posedge clock);
		`CHK("locked", 1'b0, malf)
		rd(fault_sup_pkg::STATUS_OFS, {21'h3, c[0]}, 32'hfff);
		// led patterns while the locked fault stands
		led_win("led_std", 16'h4002, 16'h8000);
		apb(1'b1, fault_sup_pkg::CTRL_OFS, 32'h2);
		{pin_r.can_state, pin_r.can_bus_off} <= 3'h5;
		led_win("led_can_on", 16'h8000, 16'h8000);
		{pin_r.can_state, pin_r.can_bus_off} <= 3'h2;
		pin_r.can_err_cnt <= 8'h61 + 8'($urandom_range(158, 0));
		led_win("led_can_warn", 16'h4010, 16'h4002);
		apb(1'b1, fault_sup_pkg::CTRL_OFS, 32'h9);
		pin_r.brake_evac <= 1'b1;
		led_win("led_link_bad", 16'h0000, 16'h4010);
		`CHK("wshort_off", 1'b0, wshort)
		pin_r.link_ok <= 1'b1;
		led_win("led_link_ok", 16'h8000, 16'h0000);
		apb(1'b1, fault_sup_pkg::CTRL_OFS, 32'h0);
		led_win("led_link_off", 16'h4001, 16'h4001);
		pin_r.fw_err_code <= 3'h3;
		led_win("led_fw_err", 16'h0000, 16'h0c03);
		pin_r.fw_err_code <= 3'h0;
		// power cycle with the monitor input held active
		evs = 16'h0101 + 16'($urandom_range(4095, 0));
		{pin_r.monitor_req, pin_r.evac_up, pin_r.brake_evac} <= 3'h7;
		pin_r.evac_speed <= evs;
		go <= 1'b1;
		rst_n <= 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (12) @(posedge clock);
		`CHK("mon_on", 1'b1, mon)
		`CHK("inhibit", 2'h0, {rdy, brk})
		`CHK("arrow", 1'b1, arrow)
		`CHK("wshort", 1'b1, wshort)
		rd(fault_sup_pkg::MON_SPEED_OFS, {15'h3, evs}, '1);
		pin_r.fault_detect <= 1'b1;
		repeat (5) @(posedge clock);
		rd(fault_sup_pkg::HIST_COUNT_OFS, 33'h0, '1);
		conclude();
	end
endmodule
